// file: logic/fwp_core.sv
/*
 * Write protection core of a serial NOR flash: write enable latch, byte-count
 * check, per-sector lock and lock-down bits, block-protect area check.
 * Assumes the command decoder presents one decoded command per valid cycle,
 * with the clock count, address and data byte, plus the stored array byte.
 */
`timescale 1ns/1ps
module fwp_core
    import fwp_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    // Decoded command
    input  wire logic              cmd_valid_i,
    input  wire fwp_cmd_e          cmd_kind_i,
    input  wire logic [CNT_W-1:0]  cmd_clocks_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [7:0]        cmd_data_i,
    input  wire logic [7:0]        arr_rd_data_i,
    // Pins and mode
    input  wire logic              write_prot_n_i,
    input  wire logic              quad_mode_i,
    // Result
    output logic                   grant_o,
    output logic                   refuse_o,
    output fwp_cause_e             cause_o,
    output fwp_cmd_e               op_kind_o,
    output logic [ADDR_W-1:0]      op_addr_o,
    output logic [7:0]             op_data_o,
    output logic                   op_otp_o,
    // Status
    output logic                   wel_o,
    output logic [3:0]             block_protect_code_o,
    output logic                   top_bottom_o
);

    // ============================================================
    // State
    localparam fwp_state_s RST_STATE = '{
        lock:   {SECTORS{LOCK_RST}},
        down:   {SECTORS{DOWN_RST}},
        wel:    WEL_RST,
        bp:     BP_RST,
        tb:     TB_RST,
        grant:  1'b0,
        refuse: 1'b0,
        cause:  FWP_OK,
        kind:   FWP_WREN,
        addr:   '0,
        data:   8'hFF,
        otp:    1'b0
    };

    fwp_state_s s_r;
    fwp_state_s s_nxt;

    fwp_geo_if geo ();

    fwp_geo_dec u_dec (
        .geo (geo)
    );

    assign geo.addr = cmd_addr_i;
    assign geo.bp   = s_r.bp;
    assign geo.tb   = s_r.tb;

    // ============================================================
    // Decision
    always_comb
    begin
        logic [SEC_W-1:0] sec;
        sec          = geo.sector;
        s_nxt        = s_r;
        s_nxt.grant  = 1'b0;
        s_nxt.refuse = 1'b0;
        if (cmd_valid_i)
        begin
            s_nxt.cause = FWP_OK;
            if (cmd_clocks_i[2:0] != 3'h0)
            begin
                // Partial byte: discarded, latch left as it was
                s_nxt.refuse = 1'b1;
                s_nxt.cause  = FWP_BITS;
            end
            else if (cmd_kind_i == FWP_WREN)
            begin
                s_nxt.wel   = 1'b1;
                s_nxt.grant = 1'b1;
                s_nxt.kind  = cmd_kind_i;
            end
            else if (cmd_kind_i == FWP_WRDI)
            begin
                s_nxt.wel   = 1'b0;
                s_nxt.grant = 1'b1;
                s_nxt.kind  = cmd_kind_i;
            end
            else if (!s_r.wel)
            begin
                s_nxt.refuse = 1'b1;
                s_nxt.cause  = FWP_NO_WEL;
            end
            else
            begin
                // Latch is spent by every whole-byte modifying command, taken or not
                s_nxt.wel = 1'b0;
                unique case (cmd_kind_i)
                    FWP_PROG, FWP_ERASE_SUB, FWP_ERASE_SEC:
                    begin
                        if (s_r.lock[sec])
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_LOCKED;
                        end
                        else if (geo.bp_hit)
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_AREA;
                        end
                        else
                        begin
                            s_nxt.grant = 1'b1;
                            s_nxt.kind  = cmd_kind_i;
                            s_nxt.otp   = 1'b0;
                            s_nxt.addr  = cmd_addr_i;
                            s_nxt.data  = 8'hFF;
                            if (cmd_kind_i == FWP_PROG)
                                s_nxt.data = arr_rd_data_i & cmd_data_i;
                            else if (cmd_kind_i == FWP_ERASE_SUB)
                                s_nxt.addr[SUB_LSB-1:0] = '0;
                            else
                                s_nxt.addr[SEC_LSB-1:0] = '0;
                        end
                    end
                    FWP_ERASE_BULK:
                    begin
                        // Whole array only if no sector is covered at all
                        if (|s_r.lock)
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_LOCKED;
                        end
                        else if (s_r.bp != BP_NONE)
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_AREA;
                        end
                        else
                        begin
                            s_nxt.grant = 1'b1;
                            s_nxt.kind  = cmd_kind_i;
                            s_nxt.otp   = 1'b0;
                            s_nxt.addr  = '0;
                            s_nxt.data  = 8'hFF;
                        end
                    end
                    FWP_WR_LOCK:
                    begin
                        if (s_r.down[sec])
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_FROZEN;
                        end
                        else
                        begin
                            s_nxt.lock[sec] = cmd_data_i[LOCK_BIT];
                            s_nxt.down[sec] = cmd_data_i[DOWN_BIT];
                            s_nxt.grant     = 1'b1;
                            s_nxt.kind      = cmd_kind_i;
                        end
                    end
                    FWP_WR_STATUS:
                    begin
                        // The pin is a data line in quad mode, so it guards nothing there
                        if (!write_prot_n_i && !quad_mode_i)
                        begin
                            s_nxt.refuse = 1'b1;
                            s_nxt.cause  = FWP_WP_PIN;
                        end
                        else
                        begin
                            s_nxt.bp    = cmd_data_i[BP_LSB +: 4];
                            s_nxt.tb    = cmd_data_i[TB_BIT];
                            s_nxt.grant = 1'b1;
                            s_nxt.kind  = cmd_kind_i;
                        end
                    end
                    FWP_OTP_PROG:
                    begin
                        // Separate area: only the low six bits select a byte
                        s_nxt.grant = 1'b1;
                        s_nxt.kind  = cmd_kind_i;
                        s_nxt.otp   = 1'b1;
                        s_nxt.addr  = {{(ADDR_W-OTP_W){1'b0}}, cmd_addr_i[OTP_W-1:0]};
                        s_nxt.data  = arr_rd_data_i & cmd_data_i;
                    end
                    default:
                    begin
                        s_nxt.refuse = 1'b1;
                        s_nxt.cause  = FWP_OK;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            s_r <= RST_STATE;
        else
            s_r <= s_nxt;
    end

    // ============================================================
    // Outputs
    assign grant_o              = s_r.grant;
    assign refuse_o             = s_r.refuse;
    assign cause_o              = s_r.cause;
    assign op_kind_o            = s_r.kind;
    assign op_addr_o            = s_r.addr;
    assign op_data_o            = s_r.data;
    assign op_otp_o             = s_r.otp;
    assign wel_o                = s_r.wel;
    assign block_protect_code_o = s_r.bp;
    assign top_bottom_o         = s_r.tb;

    // ============================================================
    // Checks
    logic is_mod;
    assign is_mod = cmd_kind_i != FWP_WREN && cmd_kind_i != FWP_WRDI;

    chk_byte_count: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && cmd_clocks_i[2:0] != 3'h0
        |=> refuse_o && !grant_o && cause_o == FWP_BITS && $stable(s_r.lock))
        else $error("partial byte command not discarded");

    chk_wel_needed: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && is_mod && cmd_clocks_i[2:0] == 3'h0 && !wel_o
        |=> refuse_o && cause_o == FWP_NO_WEL)
        else $error("modifying command taken without write enable");

    chk_wel_spent: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && is_mod && cmd_clocks_i[2:0] == 3'h0 ##1 !cmd_valid_i
        |-> !wel_o)
        else $error("write enable latch survived a modifying command");

    chk_prog_clears: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        grant_o && op_kind_o == FWP_PROG
        |-> op_data_o == ($past(arr_rd_data_i) & $past(cmd_data_i)))
        else $error("program may set a bit to one");

    chk_lock_refuse: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && cmd_kind_i == FWP_PROG && wel_o
        && cmd_clocks_i[2:0] == 3'h0 && s_r.lock[geo.sector]
        |=> refuse_o && !grant_o && cause_o == FWP_LOCKED)
        else $error("program taken in a locked sector");

    chk_area_refuse: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && cmd_kind_i == FWP_ERASE_SEC && wel_o
        && cmd_clocks_i[2:0] == 3'h0 && geo.bp_hit
        |=> refuse_o && !grant_o)
        else $error("erase taken in block-protected area");

    chk_lock_frozen: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && cmd_kind_i == FWP_WR_LOCK && s_r.down[geo.sector]
        |=> s_r.lock[$past(geo.sector)] == $past(s_r.lock[geo.sector])
            && s_r.down[$past(geo.sector)])
        else $error("frozen sector protection changed");

    chk_sub_align: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        grant_o && op_kind_o == FWP_ERASE_SUB
        |-> op_addr_o[SUB_LSB-1:0] == '0 && op_data_o == 8'hFF)
        else $error("subsector erase not aligned");

    chk_wp_pin: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        cmd_valid_i && cmd_kind_i == FWP_WR_STATUS && !write_prot_n_i
        && !quad_mode_i ##1 1'b1
        |-> $stable(block_protect_code_o) && $stable(top_bottom_o))
        else $error("protect code changed with write-protect pin low");

    cov_prog_granted: cover property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        grant_o && op_kind_o == FWP_PROG);

    cov_bulk_granted: cover property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        grant_o && op_kind_o == FWP_ERASE_BULK);

    cov_frozen_refuse: cover property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        refuse_o && cause_o == FWP_FROZEN);

    cov_area_refuse: cover property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        refuse_o && cause_o == FWP_AREA);

endmodule

// file: logic/fwp_pkg.sv
/*
 * Shared constants and types for the flash array write protection block.
 * Assumes a single 50 MHz system clock and one command presented per cycle.
 */
package fwp_pkg;

    // ============================================================
    // Array geometry
    localparam int unsigned ARRAY_BYTES  = 33554432;
    localparam int unsigned SECTORS      = 512;
    localparam int unsigned SUBSECTORS   = 8192;
    localparam int unsigned SUBS_PER_SEC = 16;
    localparam int unsigned PAGES        = 131072;
    localparam int unsigned PAGE_BYTES   = 256;
    localparam int unsigned OTP_BYTES    = 64;
    localparam int unsigned ADDR_W       = 25;
    localparam int unsigned SEC_W        = 9;
    localparam int unsigned SUB_W        = 4;
    localparam int unsigned PAGE_W       = 17;
    localparam int unsigned OTP_W        = 6;
    localparam int unsigned SEC_LSB      = 16;
    localparam int unsigned SUB_LSB      = 12;
    localparam int unsigned PAGE_LSB     = 8;
    localparam int unsigned CNT_W        = 16;

    // ============================================================
    // Protection codes and data field positions
    localparam logic [3:0]  BP_NONE      = 4'h0;
    localparam logic [3:0]  BP_LAST_SIZE = 4'h9;
    localparam logic [9:0]  BP_ALL_SIZE  = 10'h200;
    localparam int unsigned LOCK_BIT     = 0;
    localparam int unsigned DOWN_BIT     = 1;
    localparam int unsigned BP_LSB       = 2;
    localparam int unsigned TB_BIT       = 6;

    // ============================================================
    // Reset values
    localparam logic        WEL_RST      = 1'b0;
    localparam logic        LOCK_RST     = 1'b1;
    localparam logic        DOWN_RST     = 1'b0;
    localparam logic [3:0]  BP_RST       = 4'h0;
    localparam logic        TB_RST       = 1'b0;

    typedef enum logic [3:0] {
        FWP_WREN, FWP_WRDI, FWP_PROG, FWP_ERASE_SUB, FWP_ERASE_SEC,
        FWP_ERASE_BULK, FWP_WR_LOCK, FWP_WR_STATUS, FWP_OTP_PROG
    } fwp_cmd_e;

    typedef enum logic [2:0] {
        FWP_OK, FWP_BITS, FWP_NO_WEL, FWP_LOCKED, FWP_AREA, FWP_WP_PIN, FWP_FROZEN
    } fwp_cause_e;

    typedef struct packed {
        logic [SECTORS-1:0] lock;
        logic [SECTORS-1:0] down;
        logic               wel;
        logic [3:0]         bp;
        logic               tb;
        logic               grant;
        logic               refuse;
        fwp_cause_e         cause;
        fwp_cmd_e           kind;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         data;
        logic               otp;
    } fwp_state_s;

endpackage

// file: logic/fwp_geo_if.sv
/*
 * Carrier between the protection core and its address decoder.
 * Assumes the core drives address and protect code combinationally.
 */
`timescale 1ns/1ps
interface fwp_geo_if;
    import fwp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        bp;
    logic              tb;
    logic [SEC_W-1:0]  sector;
    logic [SUB_W-1:0]  subsector;
    logic [PAGE_W-1:0] page;
    logic              bp_hit;

    modport core (output addr, bp, tb, input sector, subsector, page, bp_hit);
    modport dec  (input addr, bp, tb, output sector, subsector, page, bp_hit);
endinterface

// file: logic/fwp_geo_dec.sv
/*
 * Address decoder: sector, subsector and page split plus block-protect range.
 * Assumes a purely combinational consumer in the same clock domain.
 */
`timescale 1ns/1ps
module fwp_geo_dec
    import fwp_pkg::*;
(
    // Decoder side of the carrier
    fwp_geo_if.dec geo
);

    // ============================================================
    // Protected range size in sectors for a code
    function automatic logic [9:0] bp_size(input logic [3:0] code);
        logic [9:0] s;
        s = 10'h000;
        if (code == BP_NONE)
            s = 10'h000;
        else if (code <= BP_LAST_SIZE)
            s = 10'(10'h001 << (code - 4'h1));
        else
            s = BP_ALL_SIZE;
        return s;
    endfunction

    // ============================================================
    // Geometry split
    assign geo.sector    = geo.addr[SEC_LSB +: SEC_W];
    assign geo.subsector = geo.addr[SUB_LSB +: SUB_W];
    assign geo.page      = geo.addr[PAGE_LSB +: PAGE_W];

    // ============================================================
    // Top area counts down from the last sector, bottom area up from zero
    always_comb
    begin
        logic [9:0] sz;
        logic [9:0] sec;
        sz  = bp_size(geo.bp);
        sec = {1'b0, geo.sector};
        if (geo.tb)
            geo.bp_hit = sec < sz;
        else
            geo.bp_hit = sec >= (BP_ALL_SIZE - sz);
    end

endmodule

// file: testbench/fwp_host_model.sv
/*
 * Host controller model: presents decoded commands to the protection core.
 * Assumes the core takes a command at a rising edge with valid high.
 */
`timescale 1ns/1ps
module fwp_host_model
    import fwp_pkg::*;
(
    // Clock
    input  wire logic              clk_sys_i,
    // Command
    output logic                   cmd_valid_o,
    output fwp_cmd_e               cmd_kind_o,
    output logic [CNT_W-1:0]       cmd_clocks_o,
    output logic [ADDR_W-1:0]      cmd_addr_o,
    output logic [7:0]             cmd_data_o,
    output logic [7:0]             arr_rd_data_o
);
    // ========
    // Idle state
    initial
    begin
        cmd_valid_o   = 1'b0;
        cmd_kind_o    = FWP_WREN;
        cmd_clocks_o  = 16'h0000;
        cmd_addr_o    = 25'h0000000;
        cmd_data_o    = 8'h00;
        arr_rd_data_o = 8'h00;
    end

    // ========
    // Raw command, may break the enable order on purpose
    task automatic send(input fwp_cmd_e k, input logic [CNT_W-1:0] c,
                        input logic [ADDR_W-1:0] a, input logic [7:0] d,
                        input logic [7:0] rd);
        @(posedge clk_sys_i);
        cmd_valid_o   <= 1'b1;
        cmd_kind_o    <= k;
        cmd_clocks_o  <= c;
        cmd_addr_o    <= a;
        cmd_data_o    <= d;
        arr_rd_data_o <= rd;
        @(posedge clk_sys_i);
        // Released fields other than the kind show the inverse, so a stale sample cannot pass
        cmd_valid_o   <= 1'b0;
        cmd_clocks_o  <= ~c;
        cmd_addr_o    <= ~a;
        cmd_data_o    <= ~d;
        arr_rd_data_o <= ~rd;
    endtask

    // ========
    // Modifying command, always preceded by write enable
    task automatic write_op(input fwp_cmd_e k, input logic [ADDR_W-1:0] a,
                            input logic [7:0] d, input logic [7:0] rd);
        send(FWP_WREN, 16'h0008, a, d, rd);
        send(k, 16'h0028, a, d, rd);
    endtask
endmodule

// file: testbench/fwp_core_tb.sv
/*
 * Self-checking bench for the write protection core.
 * Assumes the answer pulses one cycle after the taking edge.
 */
`timescale 1ns/1ps
module fwp_core_tb;
    import fwp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic write_prot_n_i = 1'b1;
    logic quad_mode_i = 1'b0;
    logic cmd_valid_i, grant_o, refuse_o, op_otp_o, wel_o, top_bottom_o;
    fwp_cmd_e          cmd_kind_i, op_kind_o;
    fwp_cause_e        cause_o;
    logic [CNT_W-1:0]  cmd_clocks_i;
    logic [ADDR_W-1:0] cmd_addr_i, op_addr_o;
    logic [7:0]        cmd_data_i, arr_rd_data_i, op_data_o;
    logic [3:0]        block_protect_code_o;
    int n_mismatch = 0;
    int n_tests = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    fwp_host_model i_host (.clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid_i),
        .cmd_kind_o(cmd_kind_i), .cmd_clocks_o(cmd_clocks_i), .cmd_addr_o(cmd_addr_i),
        .cmd_data_o(cmd_data_i), .arr_rd_data_o(arr_rd_data_i));

    fwp_core i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_kind_i(cmd_kind_i), .cmd_clocks_i(cmd_clocks_i), .cmd_addr_i(cmd_addr_i),
        .cmd_data_i(cmd_data_i), .arr_rd_data_i(arr_rd_data_i),
        .write_prot_n_i(write_prot_n_i), .quad_mode_i(quad_mode_i), .grant_o(grant_o),
        .refuse_o(refuse_o), .cause_o(cause_o), .op_kind_o(op_kind_o),
        .op_addr_o(op_addr_o), .op_data_o(op_data_o), .op_otp_o(op_otp_o), .wel_o(wel_o),
        .block_protect_code_o(block_protect_code_o), .top_bottom_o(top_bottom_o));

    // ========
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        print_verdict();
    end

    task automatic do_reset();
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
    endtask

    // Answer stands only in the cycle after the taking edge, so look right after it
    task automatic ans(input fwp_cause_e ec, input logic eg);
        #1;
        chk(grant_o, eg);
        chk(refuse_o, !eg);
        chk(cause_o, ec);
    endtask

    task automatic raw(input fwp_cmd_e k, input logic [15:0] c, input logic [24:0] a,
                       input fwp_cause_e ec, input logic eg);
        i_host.send(k, c, a, 8'h0F, 8'h3C);
        ans(ec, eg);
    endtask

    task automatic mop(input fwp_cmd_e k, input logic [24:0] a, input logic [7:0] d,
                       input fwp_cause_e ec, input logic eg);
        i_host.write_op(k, a, d, 8'h3C);
        ans(ec, eg);
    endtask

    function automatic logic prot(input int t, input int c, input int s);
        int sz;
        sz = 1;
        if (c == 0)
            return 1'b0;
        if (c >= 10)
            return 1'b1;
        sz = 1 << (c - 1);
        return (t == 1) ? (s < sz) : (s >= 512 - sz);
    endfunction

    // ========
    // Scenarios
    task automatic t_reset_lock();
        #1;
        chk(wel_o, 1'b0);
        chk(op_data_o, 8'hFF);
        raw(FWP_PROG, 16'h0028, 25'h0000100, FWP_NO_WEL, 1'b0);
        mop(FWP_PROG, 25'h0000100, 8'h0F, FWP_LOCKED, 1'b0);
        chk(op_addr_o, 25'h0000000);
        mop(FWP_ERASE_BULK, 25'h0000000, 8'h00, FWP_LOCKED, 1'b0);
        mop(FWP_WR_LOCK, 25'h000F000, 8'h00, FWP_OK, 1'b1);
        mop(FWP_PROG, 25'h0000100, 8'h0F, FWP_OK, 1'b1);
        chk(op_data_o, 8'h0C);
        chk(op_addr_o, 25'h0000100);
        chk(op_kind_o, FWP_PROG);
        chk(op_otp_o, 1'b0);
        chk(wel_o, 1'b0);
        mop(FWP_ERASE_SUB, 25'h0001234, 8'h00, FWP_OK, 1'b1);
        chk(op_addr_o, 25'h0001000);
        chk(op_data_o, 8'hFF);
        mop(FWP_ERASE_SEC, 25'h000ABCD, 8'h00, FWP_OK, 1'b1);
        chk(op_addr_o, 25'h0000000);
        chk(op_kind_o, FWP_ERASE_SEC);
        mop(FWP_WR_LOCK, 25'h0000000, 8'h03, FWP_OK, 1'b1);
        mop(FWP_PROG, 25'h0000100, 8'h0F, FWP_LOCKED, 1'b0);
        mop(FWP_WR_LOCK, 25'h0000000, 8'h00, FWP_FROZEN, 1'b0);
        do_reset();
        mop(FWP_PROG, 25'h0000100, 8'h0F, FWP_LOCKED, 1'b0);
        $display("test reset_lock done");
    endtask

    task automatic t_bits_otp();
        raw(FWP_WREN, 16'h0009, 25'h0000000, FWP_BITS, 1'b0);
        chk(wel_o, 1'b0);
        raw(FWP_WREN, 16'h0008, 25'h0000000, FWP_OK, 1'b1);
        raw(FWP_PROG, 16'h0029, 25'h0000100, FWP_BITS, 1'b0);
        chk(wel_o, 1'b1);
        raw(FWP_WRDI, 16'h0008, 25'h0000000, FWP_OK, 1'b1);
        chk(wel_o, 1'b0);
        i_host.write_op(FWP_OTP_PROG, 25'h1FFFF3F, 8'h55, 8'hF0);
        ans(FWP_OK, 1'b1);
        chk(op_addr_o, 25'h000003F);
        chk(op_data_o, 8'h50);
        chk(op_otp_o, 1'b1);
        $display("test bits_otp done");
    endtask

    task automatic t_pin();
        @(posedge clk_sys_i);
        write_prot_n_i <= 1'b0;
        mop(FWP_WR_STATUS, 25'h0000000, 8'h04, FWP_WP_PIN, 1'b0);
        chk(block_protect_code_o, 4'h0);
        @(posedge clk_sys_i);
        quad_mode_i <= 1'b1;
        mop(FWP_WR_STATUS, 25'h0000000, 8'h04, FWP_OK, 1'b1);
        chk(block_protect_code_o, 4'h1);
        @(posedge clk_sys_i);
        write_prot_n_i <= 1'b1;
        quad_mode_i <= 1'b0;
        $display("test pin done");
    endtask

    task automatic t_area();
        int sz;
        int p;
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 16; c++)
            begin
                sz = (c == 0) ? 1 : (c >= 10) ? 256 : (1 << (c - 1));
                mop(FWP_WR_STATUS, 25'h0, {1'b0, t[0], c[3:0], 2'b00}, FWP_OK, 1'b1);
                chk(block_protect_code_o, c[3:0]);
                chk(top_bottom_o, t[0]);
                for (int k = 0; k < 2; k++)
                begin
                    p = (t == 1) ? (sz - 1 + k) : (512 - sz - k);
                    mop(FWP_WR_LOCK, {p[8:0], 16'h0000}, 8'h00, FWP_OK, 1'b1);
                    mop(FWP_PROG, {p[8:0], 16'hF123}, 8'h0F,
                        prot(t, c, p) ? FWP_AREA : FWP_OK, !prot(t, c, p));
                end
            end
        $display("test area done");
    endtask

    // Whole-array erase needs every lock bit cleared, so all 512 are walked
    task automatic t_bulk();
        mop(FWP_WR_STATUS, 25'h0, 8'h04, FWP_OK, 1'b1);
        for (int s = 0; s < 512; s++)
            mop(FWP_WR_LOCK, {s[8:0], 16'h0000}, 8'h00, FWP_OK, 1'b1);
        mop(FWP_ERASE_SEC, 25'h1FF0000, 8'h00, FWP_AREA, 1'b0);
        mop(FWP_ERASE_BULK, 25'h0, 8'h00, FWP_AREA, 1'b0);
        mop(FWP_WR_STATUS, 25'h0, 8'h00, FWP_OK, 1'b1);
        mop(FWP_ERASE_BULK, 25'h1234567, 8'h00, FWP_OK, 1'b1);
        chk(op_kind_o, FWP_ERASE_BULK);
        chk(op_addr_o, 25'h0000000);
        chk(op_data_o, 8'hFF);
        mop(fwp_cmd_e'(4'hF), 25'h0, 8'h00, FWP_OK, 1'b0);
        chk(wel_o, 1'b0);
        $display("test bulk done");
    endtask

    initial
    begin
        do_reset();
        t_reset_lock();
        t_bits_otp();
        t_pin();
        t_area();
        t_bulk();
        print_verdict();
    end
endmodule
